// File: include/wtb_pkg.sv
// Function
// - Upper bytes compare with result bits 11:4
// - High nibble compares with result bits 3:0
// - Low nibble compares with result bits 3:0
// - Hysteresis is setting shifted left three places
// - Alert after n+1 consecutive excursions
// - High upper byte resets to all ones
// - Hysteresis register resets to F0
// - Low upper byte resets to zero
// - Count register resets to zero
package wtb_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int CH_NUM = 2;
  localparam logic [2:0] CH_FIRST = 3'h3;
  localparam int SMP_W = 12;
  localparam int SET_W = 4;
  localparam int HYST_W = 7;
  localparam int HYST_SHIFT = 3;
  localparam int BANK_N = 8;
  localparam int REGS_PER_CH = 4;

  // ----------------------------------------
  // Register map (index, byte address is index times four)
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam logic [7:0] IDX_CH3_HYST = 8'h2C;
  localparam logic [7:0] IDX_CH3_HI = 8'h2D;
  localparam logic [7:0] IDX_CH3_LO_CNT = 8'h2E;
  localparam logic [7:0] IDX_CH3_LO = 8'h2F;
  localparam logic [7:0] IDX_CH4_HYST = 8'h30;
  localparam logic [7:0] IDX_CH4_HI = 8'h31;
  localparam logic [7:0] IDX_CH4_LO_CNT = 8'h32;
  localparam logic [7:0] IDX_CH4_LO = 8'h33;
  localparam logic [7:0] IDX_STAT = 8'h40;
  localparam logic [7:0] IDX_MASK = 8'h41;

  // Slot of each register inside one channel's group of four
  localparam int OFS_HYST = 0;
  localparam int OFS_HI = 1;
  localparam int OFS_LO_CNT = 2;
  localparam int OFS_LO = 3;

  // Field positions inside the nibble-pair registers
  localparam int NIB_HI = 7;
  localparam int NIB_LO = 4;
  localparam int SET_HI = 3;
  localparam int SET_LO = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_HYST = 8'hF0;
  localparam logic [7:0] RST_HI = 8'hFF;
  localparam logic [7:0] RST_LO_CNT = 8'h00;
  localparam logic [7:0] RST_LO = 8'h00;
  localparam logic [31:0] RST_GRP = {RST_LO, RST_LO_CNT, RST_HI, RST_HYST};
  localparam logic [63:0] BANK_RST = {RST_GRP, RST_GRP};
  localparam logic [1:0] RST_MASK = 2'h0;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [SMP_W-1:0] hi;
    logic [SMP_W-1:0] lo;
    logic [SET_W-1:0] hyst;
    logic [SET_W-1:0] n;
  } wtb_cfg_s;

  typedef struct packed {
    logic vld;
    logic [2:0] chan;
    logic [SMP_W-1:0] data;
  } wtb_smp_s;

endpackage : wtb_pkg

// File: logic/wtb_chan.sv
module wtb_chan (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Settings and samples
  input wire wtb_pkg::wtb_cfg_s i_cfg,
  input wire logic i_vld,
  input wire logic [wtb_pkg::SMP_W-1:0] i_data,
  // Alert event
  output logic o_event
);
  import wtb_pkg::*;

  logic [HYST_W-1:0] hyst;
  logic [SMP_W:0] hi_diff;
  logic [SMP_W:0] lo_sum;
  logic [SMP_W-1:0] hi_m;
  logic [SMP_W-1:0] lo_p;
  logic above;
  logic below;
  logic exc;
  logic was_out_q;
  logic [SET_W-1:0] run_q;

  // ----------------------------------------
  // Window with hysteresis
  // ----------------------------------------
  assign hyst = {i_cfg.hyst, HYST_SHIFT'(0)};
  assign hi_diff = {1'b0, i_cfg.hi} - {6'h0, hyst};
  assign lo_sum = {1'b0, i_cfg.lo} + {6'h0, hyst};
  // Saturate so a wide band never wraps the window inside out
  assign hi_m = hi_diff[SMP_W] ? '0 : hi_diff[SMP_W-1:0];
  assign lo_p = lo_sum[SMP_W] ? '1 : lo_sum[SMP_W-1:0];
  // Full 12-bit compare covers both the byte and the nibble
  assign above = was_out_q ? (i_data > hi_m) : (i_data > i_cfg.hi);
  assign below = was_out_q ? (i_data < lo_p) : (i_data < i_cfg.lo);
  assign exc = above || below;

  // ----------------------------------------
  // Consecutive excursion run
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      was_out_q <= 1'b0;
      run_q <= '0;
      o_event <= 1'b0;
    end else if (i_vld) begin
      was_out_q <= exc;
      if (!exc) begin
        run_q <= '0;
      end else if (run_q < i_cfg.n) begin
        run_q <= run_q + 1'b1;
      end
      o_event <= exc && (run_q >= i_cfg.n);
    end else begin
      o_event <= 1'b0;
    end
  end

  chk_run_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_vld && !exc |=> run_q == '0 && !o_event)
    else $error("run not restarted by in-window sample");

  chk_alert_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_event |-> $past(i_vld) && $past(exc) && $past(run_q) >= $past(i_cfg.n))
    else $error("alert without n+1 excursions");

  chk_upper_cmp: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_vld && i_data > i_cfg.hi |=> o_event || run_q != '0)
    else $error("sample above high limit not counted");

  chk_lower_cmp: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_vld && i_data < i_cfg.lo |=> o_event || run_q != '0)
    else $error("sample below low limit not counted");

  chk_hyst_band: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_vld && was_out_q && i_data > hi_m && i_data <= i_cfg.hi
    |=> o_event || run_q != '0)
    else $error("hysteresis band left run early");

endmodule : wtb_chan

// File: logic/wtb_irq.sv
module wtb_irq (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Events, clears and mask
  input wire logic [wtb_pkg::CH_NUM-1:0] i_evt,
  input wire logic [wtb_pkg::CH_NUM-1:0] i_clr,
  input wire logic [wtb_pkg::CH_NUM-1:0] i_mask,
  // Status and interrupt
  output logic [wtb_pkg::CH_NUM-1:0] o_stat,
  output logic o_irq
);
  import wtb_pkg::*;

  logic [CH_NUM-1:0] stat_d;

  // Set wins over a clear in the same cycle so no alert is lost
  assign stat_d = (o_stat & ~i_clr) | i_evt;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stat <= '0;
    end else begin
      o_stat <= stat_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(stat_d & i_mask);
    end
  end

  chk_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    |(i_evt & i_clr) |=> |(o_stat & $past(i_evt)))
    else $error("status clear beat a new alert");

endmodule : wtb_irq

// File: logic/wtb_bank.sv
module wtb_bank (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // AXI4-Lite write address
  input wire logic [wtb_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read address
  input wire logic [wtb_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // AXI4-Lite read data
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Conversion results
  input wire wtb_pkg::wtb_smp_s i_smp,
  // Alerts
  output logic [wtb_pkg::CH_NUM-1:0] o_alert,
  output logic o_irq
);
  import wtb_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;
  logic wr_go;
  logic [7:0] wr_idx;
  logic [2:0] wr_slot;
  logic wr_in_bank;
  logic wr_hit;
  logic wr_en;
  logic [7:0] rd_idx;
  logic [2:0] rd_slot;
  logic rd_in_bank;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic ar_take;
  logic [7:0] reg_q [BANK_N];
  logic [CH_NUM-1:0] mask_q;
  logic [CH_NUM-1:0] clr;
  logic [CH_NUM-1:0] evt;
  logic first_q;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic top_clear(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:IDX_MSB+1] == '0;
  endfunction : top_clear

  function automatic logic in_bank(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[IDX_MSB:IDX_LSB];
    return top_clear(a) && idx >= IDX_CH3_HYST && idx <= IDX_CH4_LO;
  endfunction : in_bank

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[IDX_MSB:IDX_LSB];
    return in_bank(a) || (top_clear(a) && (idx == IDX_STAT || idx == IDX_MASK));
  endfunction : is_mapped

  assign wr_idx = aw_addr_q[IDX_MSB:IDX_LSB];
  assign wr_slot = 3'(wr_idx - IDX_CH3_HYST);
  assign wr_in_bank = in_bank(aw_addr_q);
  assign wr_hit = is_mapped(aw_addr_q);
  assign rd_idx = i_araddr[IDX_MSB:IDX_LSB];
  assign rd_slot = 3'(rd_idx - IDX_CH3_HYST);
  assign rd_in_bank = in_bank(i_araddr);
  assign rd_hit = is_mapped(i_araddr);

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  // Address and data are taken in either order and held until both are in
  assign o_awready = !aw_have_q;
  assign o_wready = !w_have_q;
  // A held response stalls the next write rather than dropping it
  assign wr_go = aw_have_q && w_have_q && !o_bvalid;
  // Only the low byte lane carries register data
  assign wr_en = wr_go && w_lane_q && wr_hit;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= i_awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w_have_q <= 1'b0;
      w_byte_q <= '0;
      w_lane_q <= 1'b0;
    end else if (i_wvalid && o_wready) begin
      w_have_q <= 1'b1;
      w_byte_q <= i_wdata[7:0];
      w_lane_q <= i_wstrb[0];
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Threshold bank
  // ----------------------------------------
  for (genvar e = 0; e < BANK_N; e++) begin : g_bank
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        reg_q[e] <= BANK_RST[e*8 +: 8];
      end else if (wr_en && wr_in_bank && wr_slot == 3'(e)) begin
        reg_q[e] <= w_byte_q;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_q <= RST_MASK;
    end else if (wr_en && wr_idx == IDX_MASK) begin
      mask_q <= w_byte_q[CH_NUM-1:0];
    end
  end

  // Writing a one clears that channel's alert
  assign clr = (wr_en && wr_idx == IDX_STAT) ? w_byte_q[CH_NUM-1:0] : '0;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign o_arready = !o_rvalid;
  assign ar_take = i_arvalid && o_arready;

  always_comb begin
    rd_byte = '0;
    if (rd_in_bank) begin
      rd_byte = reg_q[rd_slot];
    end else if (rd_hit && rd_idx == IDX_STAT) begin
      rd_byte = {6'h0, o_alert};
    end else if (rd_hit && rd_idx == IDX_MASK) begin
      rd_byte = {6'h0, mask_q};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      o_rvalid <= 1'b1;
      o_rdata <= {24'h0, rd_byte};
      o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Window comparators
  // ----------------------------------------
  for (genvar c = 0; c < CH_NUM; c++) begin : g_chan
    localparam int B = c * REGS_PER_CH;
    wtb_cfg_s cfg;
    logic vld;

    // Upper byte sits above the nibble to form each 12-bit limit
    assign cfg.hi = {reg_q[B+OFS_HI], reg_q[B+OFS_HYST][NIB_HI:NIB_LO]};
    assign cfg.lo = {reg_q[B+OFS_LO], reg_q[B+OFS_LO_CNT][NIB_HI:NIB_LO]};
    assign cfg.hyst = reg_q[B+OFS_HYST][SET_HI:SET_LO];
    assign cfg.n = reg_q[B+OFS_LO_CNT][SET_HI:SET_LO];
    assign vld = i_smp.vld && i_smp.chan == 3'(CH_FIRST + 3'(c));

    wtb_chan u_chan (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_cfg(cfg),
      .i_vld(vld),
      .i_data(i_smp.data),
      .o_event(evt[c])
    );
  end

  // ----------------------------------------
  // Alert status and interrupt
  // ----------------------------------------
  wtb_irq u_irq (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_evt(evt),
    .i_clr(clr),
    .i_mask(mask_q),
    .o_stat(o_alert),
    .o_irq(o_irq)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Marks the first edge after reset release
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  sequence s_commit;
    wr_en && wr_in_bank;
  endsequence

  sequence s_bank_read;
    ar_take && rd_in_bank && !wr_en;
  endsequence

  chk_reset_high: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    first_q |-> reg_q[OFS_HI] == RST_HI && reg_q[REGS_PER_CH+OFS_HI] == RST_HI
    && reg_q[OFS_HYST] == RST_HYST && reg_q[REGS_PER_CH+OFS_HYST] == RST_HYST)
    else $error("high limit or hysteresis reset value wrong");

  chk_reset_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    first_q |-> reg_q[OFS_LO] == RST_LO && reg_q[REGS_PER_CH+OFS_LO] == RST_LO
    && reg_q[OFS_LO_CNT] == RST_LO_CNT && reg_q[REGS_PER_CH+OFS_LO_CNT] == RST_LO_CNT)
    else $error("low limit or count reset value wrong");

  chk_bank_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_commit |=> reg_q[$past(wr_slot)] == $past(w_byte_q) && o_bvalid
    && o_bresp == RESP_OKAY)
    else $error("register write not stored");

  chk_read_back: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_bank_read |=> o_rvalid && o_rdata[7:0] == reg_q[$past(rd_slot)]
    && o_rdata[31:8] == '0)
    else $error("register read differs from stored value");

  chk_wr_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_go |=> o_bvalid && o_bresp == ($past(wr_hit) ? RESP_OKAY : RESP_SLVERR))
    else $error("write answer missing");

  chk_rd_unmapped: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ar_take && !rd_hit |=> o_rvalid && o_rresp == RESP_SLVERR && o_rdata == '0)
    else $error("unmapped read not refused");

endmodule : wtb_bank

// File: sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wtb_pkg::*;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic i_clk, i_rst_b;
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [31:0] i_wdata;
  logic [3:0] i_wstrb;
  wtb_smp_s i_smp;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [CH_NUM-1:0] o_alert;
  int fail_count;
  int n_checks;

  wtb_bank DUT (
    .i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .i_smp(i_smp), .o_alert(o_alert), .o_irq(o_irq)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Signals are read right after the edge, so they still hold the values sampled there
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge i_clk);
    i_awaddr <= {2'b00, idx, 2'b00};
    i_wdata <= {24'h0, d};
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    r = o_bresp;
    i_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    i_araddr <= {2'b00, idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
  endtask : rd

  task automatic wok(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, 4'h1, r);
    chk("bresp", r, RESP_OKAY);
  endtask : wok

  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk("rdata", d, {24'h0, exp});
    chk("rresp", r, RESP_OKAY);
  endtask : rchk

  task automatic cfg(input int c, input logic [11:0] hi, input logic [11:0] lo,
                     input logic [3:0] hy, input logic [3:0] n);
    logic [7:0] b;
    b = 8'(IDX_CH3_HYST + 4 * c);
    wok(8'(b + OFS_HYST), {hi[3:0], hy});
    wok(8'(b + OFS_HI), hi[11:4]);
    wok(8'(b + OFS_LO_CNT), {lo[3:0], n});
    wok(8'(b + OFS_LO), lo[11:4]);
  endtask : cfg

  // The second edge is the one that takes the sample
  task automatic send(input logic [2:0] c, input logic [11:0] d);
    @(posedge i_clk);
    i_smp <= {1'b1, c, d};
    @(posedge i_clk);
    i_smp.vld <= 1'b0;
  endtask : send

  task automatic settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int c = 0; c < CH_NUM; c++) begin
      rchk(8'(IDX_CH3_HYST + 4 * c), 8'hF0);
      rchk(8'(IDX_CH3_HI + 4 * c), 8'hFF);
      rchk(8'(IDX_CH3_LO_CNT + 4 * c), 8'h00);
      rchk(8'(IDX_CH3_LO + 4 * c), 8'h00);
    end
    rchk(IDX_MASK, 8'h00);
    chk("alert", 32'(o_alert), 32'h0);
  endtask : t_reset

  task automatic t_rw();
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 8; k++) wok(8'(IDX_CH3_HYST + k), 8'(8'h5A ^ (k * 8'h13)));
    for (int k = 0; k < 8; k++) rchk(8'(IDX_CH3_HYST + k), 8'(8'h5A ^ (k * 8'h13)));
    // Strobe off: write answered but ignored
    wr(IDX_CH4_LO, 8'hFF, 4'h0, r);
    chk("bresp", r, RESP_OKAY);
    rchk(IDX_CH4_LO, 8'(8'h5A ^ (7 * 8'h13)));
    wr(8'h50, 8'h11, 4'h1, r);
    chk("bresp", r, RESP_SLVERR);
    rd(8'h50, d, r);
    chk("rresp", r, RESP_SLVERR);
    chk("rdata", d, 32'h0);
  endtask : t_rw

  task automatic t_count();
    cfg(0, 12'h123, 12'h045, 4'h0, 4'h2);
    cfg(1, 12'hFFF, 12'h000, 4'h0, 4'h0);
    send(3'h3, 12'h124);
    send(3'h3, 12'h124);
    send(3'h4, 12'h800);
    send(3'h3, 12'h123);
    send(3'h3, 12'h124);
    send(3'h3, 12'h124);
    settle();
    chk("alert", 32'(o_alert), 32'h0);
    send(3'h3, 12'h124);
    settle();
    chk("alert", 32'(o_alert), 32'h1);
    rchk(IDX_STAT, 8'h01);
    chk("irq", 32'(o_irq), 32'h0);
    wok(IDX_MASK, 8'h01);
    settle();
    chk("irq", 32'(o_irq), 32'h1);
    send(3'h3, 12'h100);
    wok(IDX_STAT, 8'h01);
    settle();
    chk("alert", 32'(o_alert), 32'h0);
    chk("irq", 32'(o_irq), 32'h0);
    rchk(IDX_STAT, 8'h00);
  endtask : t_count

  task automatic t_low();
    cfg(1, 12'h7F0, 12'h045, 4'h0, 4'h0);
    send(3'h4, 12'h7F0);
    send(3'h4, 12'h045);
    settle();
    chk("alert", 32'(o_alert), 32'h0);
    send(3'h4, 12'h800);
    settle();
    chk("alert", 32'(o_alert), 32'h2);
    chk("irq", 32'(o_irq), 32'h0);
    send(3'h4, 12'h400);
    wok(IDX_STAT, 8'h02);
    send(3'h4, 12'h044);
    settle();
    chk("alert", 32'(o_alert), 32'h2);
    // Event and clear land on one edge: the alert must survive the clear
    fork
      send(3'h4, 12'h044);
      wok(IDX_STAT, 8'h02);
    join
    settle();
    chk("alert", 32'(o_alert), 32'h2);
    send(3'h4, 12'h400);
    wok(IDX_STAT, 8'h02);
    settle();
    chk("alert", 32'(o_alert), 32'h0);
  endtask : t_low

  // Without hysteresis the third sample is back inside, with it the run goes on
  task automatic t_hyst();
    cfg(0, 12'h123, 12'h045, 4'h0, 4'h1);
    send(3'h3, 12'h100);
    send(3'h3, 12'h124);
    send(3'h3, 12'h118);
    settle();
    chk("alert", 32'(o_alert), 32'h0);
    cfg(0, 12'h123, 12'h045, 4'h2, 4'h1);
    send(3'h3, 12'h100);
    send(3'h3, 12'h124);
    send(3'h3, 12'h118);
    settle();
    chk("alert", 32'(o_alert), 32'h1);
  endtask : t_hyst

  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    i_rst_b = 1'b0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_smp = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_count();
    t_low();
    t_hyst();
    tally_and_finish();
  end

  // Whole run needs well under a tenth of this span
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : tb
